//--- hw/mbt_defines.svh
// Constants shared by both ends of the module bus transfer sequencer.
// Assumes one common bus clock and plain include by bare name.
`ifndef MBT_DEFINES_SVH
`define MBT_DEFINES_SVH

// Address field width carried in the address cycle
`define MBT_ADDR_W 36
// Address cycle bit: high for a write
`define MBT_WR_BIT 36
// Address cycle bit: high for a burst
`define MBT_BURST_BIT 37
// Beats in a 32-byte burst of 8-byte beats
`define MBT_BURST_BEATS 4
// Index of the last beat of a burst
`define MBT_LAST_BEAT 2'h3
// Least read latency from address cycle, in cycles
`define MBT_MIN_RD_LAT 2
// Lowest address bit that selects a double word
`define MBT_DW_LSB 3
// Slave memory depth in double words
`define MBT_MEM_DEPTH 16

`endif

//--- hw/mbt_pkg.sv
// Types shared by both ends of the module bus transfer sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package mbt_pkg;

	// Master sequencing states
	typedef enum logic [2:0] {
		MBT_M_IDLE,
		MBT_M_ARB,
		MBT_M_ADDR,
		MBT_M_DATA,
		MBT_M_DEAD
	} mbt_mstate_t;

	// Slave response states
	typedef enum logic [1:0] {
		MBT_S_IDLE,
		MBT_S_WAIT,
		MBT_S_ACK
	} mbt_sstate_t;

	// Completion status reported by the master
	typedef enum logic [1:0] {
		MBT_ST_OK,
		MBT_ST_ERR
	} mbt_status_t;

endpackage : mbt_pkg

//--- hw/mbt_if.sv
// Shared bus wires between one master end and one slave end.
// Assumes pull-ups on control lines and holders on data lines.
`timescale 1ns/1ps
`default_nettype none

interface mbt_if;
	// Resolved wire levels seen by everyone
	logic [63:0] mux_addr_data_bus;
	logic address_strobe_n;
	logic bus_busy_n;
	logic ready_ack_n;
	logic retry_ack_n;
	logic error_ack_n;
	// Point to point arbitration lines
	logic bus_request_n;
	logic bus_grant_n;
	// Master drive and enable
	logic [63:0] m_mad_out;
	logic m_mad_oe;
	logic m_as_out;
	logic m_bb_out;
	logic m_ctl_oe;
	// Slave drive and enable
	logic [63:0] s_mad_out;
	logic s_mad_oe;
	logic s_rdy_out;
	logic s_rty_out;
	logic s_err_out;
	logic s_ack_oe;
	// Holder keeps the last driven data level
	logic [63:0] mad_hold = 64'h0;

	// Data lines: whoever enables drives, else holder
	assign mux_addr_data_bus = m_mad_oe ? m_mad_out : (s_mad_oe ? s_mad_out : mad_hold);
	always @(mux_addr_data_bus) mad_hold = mux_addr_data_bus;
	// Control lines fall back to the pull-up level
	assign address_strobe_n = m_ctl_oe ? m_as_out : 1'b1;
	assign bus_busy_n = m_ctl_oe ? m_bb_out : 1'b1;
	assign ready_ack_n = s_ack_oe ? s_rdy_out : 1'b1;
	assign retry_ack_n = s_ack_oe ? s_rty_out : 1'b1;
	assign error_ack_n = s_ack_oe ? s_err_out : 1'b1;

	// Master end
	modport master (
		input mux_addr_data_bus, ready_ack_n, retry_ack_n, error_ack_n, bus_grant_n,
		input address_strobe_n, bus_busy_n,
		output m_mad_out, m_mad_oe, m_as_out, m_bb_out, m_ctl_oe, bus_request_n
	);
	// Slave end
	modport slave (
		input mux_addr_data_bus, address_strobe_n, bus_busy_n,
		input ready_ack_n, retry_ack_n, error_ack_n,
		output s_mad_out, s_mad_oe, s_rdy_out, s_rty_out, s_err_out, s_ack_oe
	);
endinterface : mbt_if

`default_nettype wire

//--- hw/mbt_slave.sv
// Slave end: a small memory answering single and burst transfers.
// Assumes the master keeps the sequencing rules; one common clock.
`timescale 1ns/1ps
`default_nettype none
`include "mbt_defines.svh"

module mbt_slave (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Bus side
	mbt_if.slave bus,
	// Pacing controls
	input wire logic [3:0] wait_first,
	input wire logic [3:0] wait_between,
	input wire logic retry_req,
	input wire logic [2:0] error_beat,
	// Transfer report
	output logic txn_seen,
	output logic [35:0] txn_addr,
	output logic txn_write
);
	mbt_pkg::mbt_sstate_t state, next_state;
	// Latched transfer attributes
	logic is_write, is_burst, do_retry;
	logic [2:0] err_at;
	logic [35:0] addr;
	// Beat index and wait counter
	logic [1:0] beat, next_beat;
	logic [3:0] wcnt, next_wcnt;
	// Registered ack and data drives
	logic next_rdy, next_rty, next_err, next_ack_oe, next_mad_oe;
	logic [63:0] next_mad;
	// Double-word store
	logic [63:0] mem [`MBT_MEM_DEPTH];
	logic strobe, acking;

	// Address strobe seen while idle starts a transfer
	assign strobe = (state == mbt_pkg::MBT_S_IDLE) && !bus.address_strobe_n;
	// A ready beat is on the bus in this cycle
	assign acking = (state == mbt_pkg::MBT_S_ACK) && !bus.s_rdy_out;

	// Word index of a beat: start double word plus beat, wrapping at 16
	function automatic logic [3:0] widx(input logic [35:0] a, input logic [1:0] b);
		widx = a[`MBT_DW_LSB+3:`MBT_DW_LSB] + {2'h0, b};
	endfunction : widx

	// Next-state and ack selection
	always_comb begin
		logic fire;
		logic [1:0] fb;
		logic [4:0] d;
		fire = 1'b0;
		fb = beat;
		d = 5'h0;
		next_state = state;
		next_beat = beat;
		next_wcnt = wcnt;
		next_rdy = 1'b1;
		next_rty = 1'b1;
		next_err = 1'b1;
		next_ack_oe = 1'b0;
		next_mad_oe = 1'b0;
		next_mad = bus.s_mad_out;
		unique case (state)
			mbt_pkg::MBT_S_IDLE: begin
				if (strobe) begin
					d = {1'b0, wait_first} + {4'h0, ~bus.mux_addr_data_bus[`MBT_WR_BIT]};
					fb = 2'h0;
					next_beat = 2'h0;
					if (d == 5'h0) begin
						fire = 1'b1;
					end else begin
						next_wcnt = 4'(d - 5'h1);
						next_state = mbt_pkg::MBT_S_WAIT;
					end
				end
			end
			mbt_pkg::MBT_S_WAIT: begin
				if (wcnt == 4'h0) begin
					fire = 1'b1;
				end else begin
					next_wcnt = wcnt - 4'h1;
				end
			end
			mbt_pkg::MBT_S_ACK: begin
				// Retry, error or last beat closes the transfer
				if (!acking || !is_burst || beat == `MBT_LAST_BEAT) begin
					next_state = mbt_pkg::MBT_S_IDLE;
				end else begin
					next_beat = beat + 2'h1;
					fb = beat + 2'h1;
					if (wait_between == 4'h0) begin
						fire = 1'b1;
					end else begin
						next_wcnt = wait_between - 4'h1;
						next_state = mbt_pkg::MBT_S_WAIT;
					end
				end
			end
			// Unused state code: fall back to idle
			default: begin
				next_state = mbt_pkg::MBT_S_IDLE;
			end
		endcase
		if (fire) begin
			next_state = mbt_pkg::MBT_S_ACK;
			next_ack_oe = 1'b1;
			if ((strobe ? retry_req : do_retry) && fb == 2'h0) begin
				next_rty = 1'b0;
			end else if ((strobe ? error_beat : err_at) == {1'b0, fb} + 3'h1) begin
				next_err = 1'b0;
			end else begin
				next_rdy = 1'b0;
				if (strobe ? !bus.mux_addr_data_bus[`MBT_WR_BIT] : !is_write) begin
					next_mad_oe = 1'b1;
					next_mad = mem[widx(strobe ? bus.mux_addr_data_bus[35:0] : addr, fb)];
				end
			end
		end
	end

	// State, counters and ack drives
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state <= mbt_pkg::MBT_S_IDLE;
			beat <= 2'h0;
			wcnt <= 4'h0;
			bus.s_rdy_out <= 1'b1;
			bus.s_rty_out <= 1'b1;
			bus.s_err_out <= 1'b1;
			bus.s_ack_oe <= 1'b0;
			bus.s_mad_oe <= 1'b0;
			bus.s_mad_out <= 64'h0;
		end else begin
			state <= next_state;
			beat <= next_beat;
			wcnt <= next_wcnt;
			bus.s_rdy_out <= next_rdy;
			bus.s_rty_out <= next_rty;
			bus.s_err_out <= next_err;
			bus.s_ack_oe <= next_ack_oe;
			bus.s_mad_oe <= next_mad_oe;
			bus.s_mad_out <= next_mad;
		end
	end

	// Transfer attributes caught from the address cycle
	// bus-busy is never consulted
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			addr <= 36'h0;
			is_write <= 1'b0;
			is_burst <= 1'b0;
			do_retry <= 1'b0;
			err_at <= 3'h0;
			txn_seen <= 1'b0;
			txn_addr <= 36'h0;
			txn_write <= 1'b0;
		end else begin
			txn_seen <= strobe;
			if (strobe) begin
				addr <= bus.mux_addr_data_bus[35:0];
				is_write <= bus.mux_addr_data_bus[`MBT_WR_BIT];
				is_burst <= bus.mux_addr_data_bus[`MBT_BURST_BIT];
				do_retry <= retry_req;
				err_at <= error_beat;
				txn_addr <= bus.mux_addr_data_bus[35:0];
				txn_write <= bus.mux_addr_data_bus[`MBT_WR_BIT];
			end
		end
	end

	// write word taken in its ack cycle
	always_ff @(posedge sys_clk) begin
		if (acking && is_write) begin
			mem[widx(addr, beat)] <= bus.mux_addr_data_bus;
		end
	end

endmodule : mbt_slave

`default_nettype wire

//--- hw/mbt_master.sv
// Master end: requests the bus, runs one single or burst transfer.
// Assumes an outside arbiter drives the grant and holds it while
// the bus is busy; one common clock with the slave.
`timescale 1ns/1ps
`default_nettype none
`include "mbt_defines.svh"

module mbt_master (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Bus side
	mbt_if.master bus,
	// Request from the user
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic req_burst,
	input wire logic [35:0] req_addr,
	input wire logic [255:0] req_wdata,
	output logic req_ready,
	// Read data stream
	output logic rd_valid,
	output logic [63:0] rd_data,
	// Completion
	output logic done,
	output mbt_pkg::mbt_status_t done_status
);
	// Sequencer state
	mbt_pkg::mbt_mstate_t state;
	// Latched request
	logic wr, burst;
	logic [35:0] addr;
	logic [255:0] wdata;
	// Beats acknowledged so far
	logic [1:0] beat;
	// Decoded bus events
	logic accept, granted, strobe_now, err_seen, rty_seen, take, last;
	logic finish;

	// User request taken while idle
	assign accept = req_valid && req_ready;
	// Grant is an active-low level from the arbiter
	assign granted = !bus.bus_grant_n;
	assign strobe_now = granted && (state == mbt_pkg::MBT_M_ARB || state == mbt_pkg::MBT_M_DEAD);
	// Acks only count in the data phase; error ranks first
	assign err_seen = (state == mbt_pkg::MBT_M_DATA) && !bus.error_ack_n;
	assign rty_seen = (state == mbt_pkg::MBT_M_DATA) && bus.error_ack_n && !bus.retry_ack_n;
	assign take = (state == mbt_pkg::MBT_M_DATA) && bus.error_ack_n && bus.retry_ack_n &&
		!bus.ready_ack_n;
	assign last = !burst || beat == `MBT_LAST_BEAT;
	// Transfer is over: last beat or an error
	assign finish = err_seen || (take && last);

	// Pick one 64-bit beat from the latched write block
	function automatic logic [63:0] wbeat(input logic [255:0] w, input logic [1:0] b);
		wbeat = w[{b, 6'h0} +: 64];
	endfunction : wbeat

	// Sequencer state transitions
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state <= mbt_pkg::MBT_M_IDLE;
		end else begin
			unique case (state)
				mbt_pkg::MBT_M_IDLE: begin
					// Wait for a request, then ask for the bus
					if (accept) begin
						state <= mbt_pkg::MBT_M_ARB;
					end
				end
				mbt_pkg::MBT_M_ARB: begin
					// Hold off until the grant is in hand
					if (granted) begin
						state <= mbt_pkg::MBT_M_ADDR;
					end
				end
				mbt_pkg::MBT_M_ADDR: begin
					// Address cycle lasts exactly one cycle
					state <= mbt_pkg::MBT_M_DATA;
				end
				mbt_pkg::MBT_M_DATA: begin
					if (finish) begin
						state <= mbt_pkg::MBT_M_IDLE;
					end else if (rty_seen) begin
						state <= mbt_pkg::MBT_M_DEAD;
					end
				end
				mbt_pkg::MBT_M_DEAD: begin
					if (granted) begin
						state <= mbt_pkg::MBT_M_ADDR;
					end else begin
						state <= mbt_pkg::MBT_M_ARB;
					end
				end
				// Unused state code: fall back to idle
				default: begin
					state <= mbt_pkg::MBT_M_IDLE;
				end
			endcase
		end
	end

	// Request latch and user handshake
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			req_ready <= 1'b1;
			wr <= 1'b0;
			burst <= 1'b0;
			addr <= 36'h0;
			wdata <= 256'h0;
		end else begin
			if (accept) begin
				req_ready <= 1'b0;
				wr <= req_write;
				burst <= req_burst;
				addr <= req_addr;
				wdata <= req_wdata;
			end else if (finish) begin
				// Ready again in the cycle after completion
				req_ready <= 1'b1;
			end
		end
	end

	// Beat counter over the data phase
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			beat <= 2'h0;
		end else if (state == mbt_pkg::MBT_M_ADDR) begin
			// Every attempt, retried or not, starts at beat 0
			beat <= 2'h0;
		end else if (take && !last) begin
			beat <= beat + 2'h1;
		end
	end

	// Bus request line toward the arbiter
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			bus.bus_request_n <= 1'b1;
		end else if (accept) begin
			bus.bus_request_n <= 1'b0;
		end else if (state == mbt_pkg::MBT_M_DEAD && !granted) begin
			// Lost the grant during a retry: ask again
			bus.bus_request_n <= 1'b0;
		end else if (granted) begin
			// Request drops once the grant is obtained
			bus.bus_request_n <= 1'b1;
		end
	end

	// Address strobe, bus-busy and their shared enable
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			bus.m_as_out <= 1'b1;
			bus.m_bb_out <= 1'b1;
			bus.m_ctl_oe <= 1'b0;
		end else begin
			// Strobe is a one-cycle low pulse
			bus.m_as_out <= !strobe_now;
			if (strobe_now) begin
				bus.m_bb_out <= 1'b0;
				bus.m_ctl_oe <= 1'b1;
			end else if (finish || (state == mbt_pkg::MBT_M_DEAD && !granted)) begin
				// early busy release is one choice
				bus.m_bb_out <= 1'b1;
				bus.m_ctl_oe <= 1'b0;
			end
		end
	end

	// Multiplexed address/data drive
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			bus.m_mad_out <= 64'h0;
			bus.m_mad_oe <= 1'b0;
		end else begin
			if (strobe_now) begin
				// Address cycle word: address, direction, size
				bus.m_mad_out <= {26'h0, burst, wr, addr};
				bus.m_mad_oe <= 1'b1;
			end else if (state == mbt_pkg::MBT_M_ADDR) begin
				// first write word without a gap
				bus.m_mad_out <= wbeat(wdata, 2'h0);
				bus.m_mad_oe <= wr;
			end else if (take && !last && wr) begin
				bus.m_mad_out <= wbeat(wdata, beat + 2'h1);
			end else if (finish || rty_seen) begin
				// Free the data lines for the next owner
				bus.m_mad_oe <= 1'b0;
			end
		end
	end

	// Read data capture
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rd_valid <= 1'b0;
			rd_data <= 64'h0;
		end else begin
			// data taken on its ready cycle
			rd_valid <= take && !wr;
			if (take && !wr) begin
				rd_data <= bus.mux_addr_data_bus;
			end
		end
	end

	// Completion pulse and status
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			done <= 1'b0;
			done_status <= mbt_pkg::MBT_ST_OK;
		end else begin
			// write ends only on slave ack
			done <= finish;
			if (finish) begin
				done_status <= err_seen ? mbt_pkg::MBT_ST_ERR : mbt_pkg::MBT_ST_OK;
			end
		end
	end

endmodule : mbt_master

`default_nettype wire

//--- bench/mbt_sva.sv
// Checker for the shared bus wires between master and slave ends.
// Assumes one clock, reset active low, fed from the interface signals.
`timescale 1ns/1ps
`default_nettype none

module mbt_sva (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Resolved bus wires
	input wire logic [63:0] mux_addr_data_bus,
	input wire logic address_strobe_n,
	input wire logic bus_busy_n,
	input wire logic ready_ack_n,
	input wire logic retry_ack_n,
	input wire logic error_ack_n,
	input wire logic bus_grant_n,
	// Data drive enables
	input wire logic m_mad_oe,
	input wire logic s_mad_oe
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	logic burst_q; // Burst bit of the running transfer
	logic [2:0] ack_cnt; // Ready acks seen since the strobe
	logic [2:0] last_idx; // Count value of the final ack

	// Track burst kind and acknowledged beats
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			burst_q <= 1'b0;
			ack_cnt <= 3'h0;
		end else if (!address_strobe_n) begin
			burst_q <= mux_addr_data_bus[37];
			ack_cnt <= 3'h0;
		end else if (!ready_ack_n) begin
			ack_cnt <= ack_cnt + 3'h1;
		end
	end
	assign last_idx = burst_q ? 3'h3 : 3'h0;

	chk_strobe_granted: assert property (!address_strobe_n |-> !bus_grant_n)
		else $error("strobe without grant");
	chk_wdata_next: assert property (!address_strobe_n && mux_addr_data_bus[36] |=> m_mad_oe)
		else $error("write data not driven after address");
	chk_read_latency: assert property (!address_strobe_n && !mux_addr_data_bus[36] |=> ready_ack_n)
		else $error("read answered too early");
	chk_write_min: assert property (!address_strobe_n |-> ready_ack_n && error_ack_n)
		else $error("ack in address cycle");
	chk_retry_dead: assert property (!retry_ack_n && !bus_grant_n |=> address_strobe_n && !bus_busy_n)
		else $error("no dead cycle after retry");
	chk_error_abort: assert property (!error_ack_n |=> bus_busy_n && !m_mad_oe)
		else $error("transfer not aborted on error");
	chk_beat_count: assert property (!ready_ack_n |-> ack_cnt <= last_idx)
		else $error("too many beats");
	chk_last_beat: assert property (!ready_ack_n && ack_cnt == last_idx |=> bus_busy_n)
		else $error("transfer not ended after last beat");
	chk_word_holds: assert property (m_mad_oe && address_strobe_n && ready_ack_n && retry_ack_n && error_ack_n
		|=> m_mad_oe && $stable(mux_addr_data_bus))
		else $error("write word changed during wait");
	chk_next_word: assert property (!ready_ack_n && m_mad_oe && ack_cnt < last_idx
		|=> m_mad_oe && !$stable(mux_addr_data_bus))
		else $error("next write word not driven");
	chk_single_driver: assert property (!(m_mad_oe && s_mad_oe))
		else $error("both ends drive data");

	// Main scenarios
	cov_burst_end: cover property (!ready_ack_n && burst_q && ack_cnt == 3'h3);
	cov_retry: cover property (!retry_ack_n ##2 !address_strobe_n);
	cov_error_late: cover property (!error_ack_n && ack_cnt == 3'h2);
endmodule : mbt_sva

`default_nettype wire

//--- bench/testbench.sv
// Self-checking bench joining master and slave through the bus interface.
// Assumes the bench acts as arbiter and user; inputs change at falling edges.
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic sys_clk = 1'b0; // 250 MHz clock
	logic resetn = 1'b0; // Reset, active low
	logic req_valid = 1'b0, req_write = 1'b0, req_burst = 1'b0; // User request
	logic [35:0] req_addr = 36'h0;
	logic [255:0] req_wdata = 256'h0;
	logic req_ready, rd_valid, done; // Master answers
	logic [63:0] rd_data;
	mbt_pkg::mbt_status_t done_status;
	logic [3:0] wait_first = 4'h0, wait_between = 4'h0; // Slave pacing
	logic retry_req = 1'b0;
	logic [2:0] error_beat = 3'h0;
	logic txn_seen, txn_write; // Slave report
	logic [35:0] txn_addr;
	logic [63:0] mem [16]; // Expected slave contents
	logic [63:0] exp_rd [$]; // Expected read words
	logic [1:0] exp_st [$]; // Expected statuses
	logic [31:0] seed = 32'h9ecf63f1;
	int num_errors = 0, cmp_count = 0, i;

	mbt_if bus_if ();
	mbt_master mbt_master_inst (.sys_clk(sys_clk), .resetn(resetn), .bus(bus_if), .req_valid(req_valid),
		.req_write(req_write), .req_burst(req_burst), .req_addr(req_addr), .req_wdata(req_wdata),
		.req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .done_status(done_status));
	mbt_slave mbt_slave_inst (.sys_clk(sys_clk), .resetn(resetn), .bus(bus_if), .wait_first(wait_first),
		.wait_between(wait_between), .retry_req(retry_req), .error_beat(error_beat), .txn_seen(txn_seen),
		.txn_addr(txn_addr), .txn_write(txn_write));
	mbt_sva mbt_sva_inst (.sys_clk(sys_clk), .resetn(resetn), .mux_addr_data_bus(bus_if.mux_addr_data_bus),
		.address_strobe_n(bus_if.address_strobe_n), .bus_busy_n(bus_if.bus_busy_n),
		.ready_ack_n(bus_if.ready_ack_n), .retry_ack_n(bus_if.retry_ack_n), .error_ack_n(bus_if.error_ack_n),
		.bus_grant_n(bus_if.bus_grant_n), .m_mad_oe(bus_if.m_mad_oe), .s_mad_oe(bus_if.s_mad_oe));

	// Clock generator
	always #2 sys_clk = ~sys_clk;

	// Pseudo random step
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// Compare and count
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Verdict and stop
	task automatic end_of_test();
		$display("comparisons %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : end_of_test

	// One transfer: note expectations, drive request, wait for done
	task automatic run(input logic w, input logic b, input logic [35:0] a, input logic [3:0] wf,
		input logic [3:0] wb, input logic rty, input logic [2:0] eb);
		logic [255:0] wd;
		logic [3:0] ix;
		int nb, lim, k;
		for (k = 0; k < 8; k++) begin
			seed = lfsr(seed);
			wd[32*k +: 32] = seed;
		end
		nb = b ? 4 : 1;
		lim = (eb != 3'h0 && eb <= nb) ? eb - 1 : nb;
		for (k = 0; k < lim; k++) begin
			ix = a[6:3] + k[3:0];
			if (w) mem[ix] = wd[64*k +: 64];
			else exp_rd.push_back(mem[ix]);
		end
		exp_st.push_back(lim < nb ? 2'h1 : 2'h0);
		@(negedge sys_clk);
		bus_if.bus_grant_n = 1'b1;
		{req_valid, req_write, req_burst, req_addr, req_wdata} = {1'b1, w, b, a, wd};
		{wait_first, wait_between, retry_req, error_beat} = {wf, wb, rty, eb};
		@(negedge sys_clk);
		req_valid = 1'b0;
		check("req_ready_busy", {63'h0, req_ready}, 64'h0);
		repeat (2) @(negedge sys_clk);
		check("bus_request_n", {63'h0, bus_if.bus_request_n}, 64'h0);
		bus_if.bus_grant_n = 1'b0;
		for (k = 0; k < 300 && done !== 1'b1; k++) begin
			@(negedge sys_clk);
			if (txn_seen === 1'b1) begin
				retry_req = 1'b0;
				check("txn_addr", {28'h0, txn_addr}, {28'h0, a});
				check("txn_write", {63'h0, txn_write}, {63'h0, w});
			end
		end
		if (k == 300) begin
			num_errors++;
			end_of_test();
		end
	endtask : run

	// Watch outputs and compare with the oldest note
	always @(negedge sys_clk) begin
		if (rd_valid === 1'b1) begin
			if (exp_rd.size() == 0) check("rd_extra", 64'h1, 64'h0);
			else check("rd_data", rd_data, exp_rd.pop_front());
		end
		if (done === 1'b1) begin
			if (exp_st.size() == 0) check("done_extra", 64'h1, 64'h0);
			else check("done_status", {62'h0, done_status}, {62'h0, exp_st.pop_front()});
		end
	end

	// Main sequence
	initial begin
		bus_if.bus_grant_n = 1'b1;
		repeat (4) @(negedge sys_clk);
		resetn = 1'b1;
		check("req_ready", {63'h0, req_ready}, 64'h1);
		for (i = 0; i < 4; i++) run(1'b1, 1'b1, 36'(i * 32), 4'(i), 4'(i), 1'b0, 3'h0);
		run(1'b1, 1'b0, 36'h8, 4'h0, 4'h0, 1'b0, 3'h0);
		run(1'b0, 1'b0, 36'h8, 4'h0, 4'h0, 1'b0, 3'h0);
		run(1'b0, 1'b1, 36'h18, 4'h3, 4'h1, 1'b0, 3'h0);
		run(1'b0, 1'b1, 36'h78, 4'h0, 4'h0, 1'b0, 3'h0);
		run(1'b0, 1'b0, 36'h10, 4'h0, 4'h0, 1'b1, 3'h0);
		run(1'b1, 1'b1, 36'h20, 4'h1, 4'h0, 1'b1, 3'h0);
		for (i = 1; i < 5; i++) begin
			run(1'b0, 1'b1, 36'h40, 4'h0, 4'h1, 1'b0, 3'(i));
			run(1'b1, 1'b1, 36'h48, 4'h1, 4'h0, 1'b0, 3'(i));
			run(1'b0, 1'b1, 36'h48, 4'h0, 4'h0, 1'b0, 3'h0);
		end
		// Random mix of kinds and pacing
		for (i = 0; i < 24; i++) begin
			seed = lfsr(seed);
			run(seed[0], seed[1], {4'h0, seed}, {2'h0, seed[9:8]}, {2'h0, seed[11:10]}, 1'b0, 3'h0);
		end
		repeat (4) @(negedge sys_clk);
		check("rd_left", 64'(exp_rd.size()), 64'h0);
		check("st_left", 64'(exp_st.size()), 64'h0);
		end_of_test();
	end
endmodule : testbench

`default_nettype wire
